/* File: inc/mbr_pkg.sv */
// constants for the per-class minimum bandwidth register bank
package mbr_pkg;
   localparam int unsigned DOMAINS       = 2;
   localparam int unsigned DOM_W         = 1;
   localparam int unsigned CLASSES       = 16;
   localparam int unsigned CLASS_IDX_W   = 4;
   localparam int unsigned CLASS_W       = 6;
   localparam int unsigned MAX_CLASSES   = 64;
   localparam int unsigned REGION_W      = 5;
   localparam int unsigned LANE_W        = 2;
   localparam int unsigned LANES         = 4;
   localparam int unsigned BW_W          = 9;
   localparam int unsigned DATA_W        = 64;
   localparam int unsigned OFFS_W        = 16;
   localparam int unsigned BLOCK_UNITS   = 1;
   localparam int unsigned BLOCK_UNIT_B  = 4096;
   localparam int unsigned BANK_B        = 512;
   localparam int unsigned REG_B         = 8;
   localparam int unsigned GROUP_W       = 3;
   localparam int unsigned ENTRY_W       = DOM_W + GROUP_W + CLASS_IDX_W;
   localparam int unsigned ENTRIES       = DOMAINS * (1 << GROUP_W) * CLASSES;
   localparam int unsigned FIELD_STRIDE  = 16;
   localparam int unsigned CLASS_LSB     = 3;
   localparam int unsigned GROUP_LSB     = 9;
   localparam logic [OFFS_W-1:0] BLOCK_END =
      OFFS_W'(BLOCK_UNITS * BLOCK_UNIT_B);
   localparam logic [2:0]        ALIGN_ZERO = 3'h0;
   localparam logic [BW_W-1:0]   BW_RESET   = 9'h1FF;
   localparam logic [BW_W-1:0]   BW_LEAST   = 9'h001;
   localparam logic [DATA_W-1:0] DATA_ZERO  = 64'h0000_0000_0000_0000;
endpackage

/* File: hdl/mbr_min_bw_regs.sv */
// minimum bandwidth register bank, one copy per resource domain
// Contract
// (RL1) each register holds four 9-bit read-write fields, one per region.
// (RL2) reset loads 1FFh into every regional field.
// (RL3) a field ranges from 001h, the least window, to 1FFh, the largest; the code stores any written value, 000h included.
// (RL4) each register sets the per-class minimum window of four regions.
// (RL5) the offset is (region/4)*512 plus class*8 from the block base.
// (RL6) the block spans block-size times 4096 bytes and nothing beyond.
// (RL7) each 512-byte bank holds up to 64 classes for four regions.
// (RL8) software uses this indexing only when the indexing version is 1.
// (RL9) class registers sit in class order from the bank start.
// (RL10) every resource domain has its own independent register set.
// (RL11) classes are zero-based and only those up to the maximum are kept.
// (RL12) reserved bits 63:57, 47:41, 31:25 and 15:9 stay zero.
// (RL13) unimplemented offsets read zero and ignore writes.
`timescale 1ns/1ps
module mbr_min_bw_regs (
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   input  wire logic                          reg_req,
   input  wire logic                          reg_write,
   input  wire logic [mbr_pkg::DOM_W-1:0]     reg_domain,
   input  wire logic [mbr_pkg::OFFS_W-1:0]    reg_offset,
   input  wire logic [mbr_pkg::DATA_W-1:0]    reg_wdata,
   output logic                               reg_ack,
   output logic                               reg_hit,
   output logic [mbr_pkg::DATA_W-1:0]         reg_rdata,
   input  wire logic [mbr_pkg::DOM_W-1:0]     query_domain,
   input  wire logic [mbr_pkg::CLASS_W-1:0]   query_class,
   input  wire logic [mbr_pkg::REGION_W-1:0]  query_region,
   output logic [mbr_pkg::BW_W-1:0]           query_bw
);

   // field geometry
   localparam int unsigned LANES    = mbr_pkg::LANES;
   localparam int unsigned BW_W     = mbr_pkg::BW_W;
   localparam int unsigned STRIDE   = mbr_pkg::FIELD_STRIDE;
   localparam int unsigned GAP_W    = STRIDE - BW_W;
   localparam int unsigned LW       = LANES * BW_W;

   // address and storage geometry
   localparam int unsigned DOMAINS  = mbr_pkg::DOMAINS;
   localparam int unsigned DOM_W    = mbr_pkg::DOM_W;
   localparam int unsigned CLASS_W  = mbr_pkg::CLASS_W;
   localparam int unsigned CIDX_W   = mbr_pkg::CLASS_IDX_W;
   localparam int unsigned GROUP_W  = mbr_pkg::GROUP_W;
   localparam int unsigned LANE_W   = mbr_pkg::LANE_W;
   localparam int unsigned REGION_W = mbr_pkg::REGION_W;
   localparam int unsigned SLOT_W   = mbr_pkg::ENTRY_W - DOM_W;
   localparam int unsigned SLOTS    = mbr_pkg::ENTRIES / DOMAINS;

   localparam logic [CLASS_W-1:0] CLASS_LIMIT  =
      CLASS_W'(mbr_pkg::CLASSES);
   localparam logic [GAP_W-1:0]   GAP_ZERO     = '0;
   localparam logic [LW-1:0]      FIELDS_RESET =
      {LANES{mbr_pkg::BW_RESET}};

   // access side: split the byte offset into bank, class and byte
   wire logic [GROUP_W-1:0] acc_group =
      reg_offset[mbr_pkg::GROUP_LSB +: GROUP_W]; // RL5 RL7

   wire logic [CLASS_W-1:0] acc_class =
      reg_offset[mbr_pkg::CLASS_LSB +: CLASS_W]; // RL5 RL9

   wire logic [mbr_pkg::CLASS_LSB-1:0] acc_byte =
      reg_offset[mbr_pkg::CLASS_LSB-1:0];

   wire logic [CIDX_W-1:0] acc_slot =
      acc_class[CIDX_W-1:0];

   // bank first, then class in order from the bank start
   wire logic [SLOT_W-1:0] acc_idx =
      {acc_group, acc_slot}; // RL9

   // backed only inside the block, aligned and on a kept class
   wire logic in_block =
      reg_offset < mbr_pkg::BLOCK_END; // RL6

   wire logic aligned =
      acc_byte == mbr_pkg::ALIGN_ZERO;

   wire logic class_ok =
      acc_class < CLASS_LIMIT; // RL11

   wire logic acc_hit =
      in_block && aligned && class_ok; // RL13

   wire logic acc_rd =
      reg_req && !reg_write;

   wire logic acc_wr =
      reg_req && reg_write;

   wire logic do_read =
      acc_rd && acc_hit; // RL13

   // a write to a hole is dropped here, so nothing downstream sees it
   wire logic do_write =
      acc_wr && acc_hit; // RL13

   // the reserved gaps are dropped on the way in and zero on the way out
   wire logic [LW-1:0]              wr_fields;
   wire logic [LW-1:0]              rd_fields;
   wire logic [mbr_pkg::DATA_W-1:0] rd_word;

   generate
      for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
         wire logic [BW_W-1:0] wr_bw =
            reg_wdata[lane*STRIDE +: BW_W]; // RL1
         wire logic [BW_W-1:0] rd_bw =
            rd_fields[lane*BW_W +: BW_W]; // RL1
         assign wr_fields[lane*BW_W +: BW_W] = wr_bw; // RL12
         assign rd_word[lane*STRIDE +: STRIDE] = {GAP_ZERO, rd_bw}; // RL12
      end
   endgenerate

   // lookup side used by the enforcement logic
   wire logic [GROUP_W-1:0] q_group =
      query_region[REGION_W-1:LANE_W]; // RL5

   wire logic [LANE_W-1:0] q_lane =
      query_region[LANE_W-1:0];

   wire logic [CIDX_W-1:0] q_slot =
      query_class[CIDX_W-1:0];

   wire logic [SLOT_W-1:0] q_idx =
      {q_group, q_slot}; // RL9

   wire logic q_ok =
      query_class < CLASS_LIMIT; // RL11

   // one storage array per domain, so no write can leak across domains
   wire logic [LW-1:0] dom_rd_fields [DOMAINS];
   wire logic [LW-1:0] dom_q_fields  [DOMAINS];

   generate
      for (genvar dom = 0; dom < DOMAINS; dom++) begin : g_dom
         logic [LW-1:0]         store [SLOTS];
         wire logic [DOM_W-1:0] dom_id = DOM_W'(dom);
         wire logic             wr_here =
            do_write && (reg_domain == dom_id); // RL10

         // reset sweeps every class at once; no per-entry valid is kept
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               for (int e = 0; e < SLOTS; e++) begin
                  store[e] <= FIELDS_RESET; // RL2
               end
            end else if (wr_here) begin
               store[acc_idx] <= wr_fields; // RL1
            end
         end

         assign dom_rd_fields[dom] = store[acc_idx];
         assign dom_q_fields[dom]  = store[q_idx];
      end
   endgenerate

   assign rd_fields = dom_rd_fields[reg_domain]; // RL10

   wire logic [LW-1:0] q_fields =
      dom_q_fields[query_domain]; // RL10

   // read data is zero for writes, holes and idle cycles
   wire logic [mbr_pkg::DATA_W-1:0] next_rdata =
      do_read ? rd_word : mbr_pkg::DATA_ZERO; // RL13

   wire logic next_ack =
      reg_req;

   wire logic next_hit =
      reg_req && acc_hit; // RL13

   wire logic [BW_W-1:0] q_pick =
      q_fields[q_lane*BW_W +: BW_W]; // RL4

   // an unbacked class gets the least window rather than an unlimited one
   wire logic [BW_W-1:0] next_query_bw =
      q_ok ? q_pick : mbr_pkg::BW_LEAST; // RL3

   // every request is answered one cycle later, backed or not
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_ack <= 1'b0;
      end else begin
         reg_ack <= next_ack;
      end
   end

   // hit tells software whether the offset had storage behind it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_hit <= 1'b0;
      end else begin
         reg_hit <= next_hit; // RL13
      end
   end

   // read data is registered so it stands a full cycle with the ack
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= mbr_pkg::DATA_ZERO;
      end else begin
         reg_rdata <= next_rdata; // RL13
      end
   end

   // the window lags the lookup inputs by one cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         query_bw <= mbr_pkg::BW_RESET; // RL2
      end else begin
         query_bw <= next_query_bw; // RL4
      end
   end

   // limitation: a read in the same cycle as a write to the same entry
   // returns the old word; the new one is visible from the next cycle
endmodule

/* File: verif/mbr_min_bw_regs_checker.sv */
// port assertions for the bandwidth register bank
`timescale 1ns/1ps
module mbr_chk (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        reg_req,
   input wire logic        reg_write,
   input wire logic [15:0] reg_offset,
   input wire logic        reg_ack,
   input wire logic        reg_hit,
   input wire logic [63:0] reg_rdata,
   input wire logic [5:0]  query_class,
   input wire logic [8:0]  query_bw
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_bad; reg_req && (reg_offset >= 16'h1000
      || reg_offset[2:0] != 3'h0 || reg_offset[8:3] > 6'h0F); endsequence
   sequence s_good; reg_req && reg_offset < 16'h1000
      && reg_offset[2:0] == 3'h0 && reg_offset[8:3] < 6'h10; endsequence
   property p_ack; reg_req |=> reg_ack; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_idle; !reg_req |=> !reg_ack && !reg_hit; endproperty
   a_idle: assert property (p_idle) else $error("stray ack");
   property p_rsv; (reg_rdata & 64'hFE00_FE00_FE00_FE00) == 64'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("gap bits set");
   property p_wr; reg_req && reg_write |=> reg_rdata == 64'h0; endproperty
   a_wr: assert property (p_wr) else $error("write data back");
   property p_bad; s_bad |=> !reg_hit && reg_rdata == 64'h0; endproperty
   a_bad: assert property (p_bad) else $error("hole answered");
   property p_good; s_good |=> reg_hit; endproperty
   a_good: assert property (p_good) else $error("miss on backed");
   property p_end; reg_req && reg_offset > 16'h0FFF |=> !reg_hit; endproperty
   a_end: assert property (p_end) else $error("hit past end");
   property p_cls; query_class > 6'h0F |=> query_bw == 9'h001; endproperty
   a_cls: assert property (p_cls) else $error("unbacked class");
   property p_rst; $rose(rst_n) |-> query_bw == 9'h1FF; endproperty
   a_rst: assert property (p_rst) else $error("reset window");
endmodule
bind mbr_min_bw_regs mbr_chk u_chk (
   .mclk        (mclk),
   .rst_n       (rst_n),
   .reg_req     (reg_req),
   .reg_write   (reg_write),
   .reg_offset  (reg_offset),
   .reg_ack     (reg_ack),
   .reg_hit     (reg_hit),
   .reg_rdata   (reg_rdata),
   .query_class (query_class),
   .query_bw    (query_bw)
);

/* File: verif/tb_min_bw_alloc_regs.sv */
// random and corner-case bench for the bandwidth register bank
`timescale 1ns/1ps
module tb_min_bw_alloc_regs;
   localparam logic [63:0] FMASK = 64'h01FF_01FF_01FF_01FF;
   logic        mclk = 0, rst_n = 0, reg_req = 0, reg_write = 0;
   logic [0:0]  reg_domain = 0, query_domain = 0, dsel;
   logic [15:0] reg_offset = 0, o;
   logic [63:0] reg_wdata = 0, reg_rdata, w, e;
   logic        reg_ack, reg_hit, wsel;
   logic [5:0]  query_class = 0;
   logic [4:0]  query_region = 0;
   logic [8:0]  query_bw;
   logic [63:0] mdl [2][16][8];
   logic [15:0] tbl [6] = '{16'h0000, 16'h0E78, 16'h1000, 16'h0080,
                            16'h0004, 16'hFFF8};
   int          n_fail = 0, checks_done = 0;
   mbr_min_bw_regs dut_u (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .reg_req      (reg_req),
      .reg_write    (reg_write),
      .reg_domain   (reg_domain),
      .reg_offset   (reg_offset),
      .reg_wdata    (reg_wdata),
      .reg_ack      (reg_ack),
      .reg_hit      (reg_hit),
      .reg_rdata    (reg_rdata),
      .query_domain (query_domain),
      .query_class  (query_class),
      .query_region (query_region),
      .query_bw     (query_bw)
   );
   initial forever #5 mclk = ~mclk;
   function automatic logic ok(logic [15:0] a);
      return a < 16'h1000 && a[2:0] == 3'h0 && a[8:3] < 6'h10;
   endfunction
   task automatic cmp(logic [63:0] g, x);
      checks_done++;
      if (g !== x) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic acc(logic wr, logic [0:0] d);
      @(posedge mclk);
      {reg_req, reg_write, reg_domain, reg_offset, reg_wdata} <= {1'b1,
         wr, d, o, w};
      @(posedge mclk);
      reg_req <= 1'b0;
      e = ok(o) && !wr ? mdl[d][o[8:3]][o[11:9]] : 64'h0;
      if (ok(o) && wr) mdl[d][o[8:3]][o[11:9]] = w & FMASK;
      @(negedge mclk);
      cmp(64'({reg_ack, reg_hit}), 64'({1'b1, ok(o)}));
      cmp(reg_rdata, e);
   endtask
   task automatic qry(logic [0:0] d, logic [5:0] c, logic [4:0] r);
      @(posedge mclk);
      {query_domain, query_class, query_region} <= {d, c, r};
      e = c < 6'h10 ? mdl[d][c[3:0]][r[4:2]] >> (16 * r[1:0]) : 64'h1;
      @(posedge mclk);
      @(negedge mclk);
      cmp(64'(query_bw), 64'(e[8:0]));
   endtask
   task conclude;
      if (n_fail == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(65));
      for (int p = 0; p < 2; p++) begin
         @(posedge mclk);
         rst_n <= 1'b0;
         repeat (20) @(posedge mclk);
         rst_n <= 1'b1;
         foreach (mdl[a, b, c]) mdl[a][b][c] = FMASK;
         for (int i = 0; i < 400; i++) begin
            w = 64'h0;
            for (int k = 0; k < 4; k++) begin
               w[16*k +: 9] = 9'($urandom_range(511, 1));
            end
            o = 16'($urandom_range(7) * 512
                + $urandom_range(15) * 8);
            if ($urandom_range(7) == 0) o = 16'($urandom);
            if (i < 6) o = tbl[i];
            wsel = i > 5 && $urandom_range(1) == 1;
            dsel = 1'($urandom_range(1));
            acc(wsel, dsel);
            qry(1'($urandom_range(1)), 6'($urandom_range(17)),
                5'($urandom));
         end
      end
      conclude;
   end
endmodule
